// file: bench/test_wtc_core.sv
/*
  self-checking bench for the watch timer core: apb master tasks, an
  expectation queue checked by a read monitor, directed and random cases.
  assumes wtc_pkg and wtc_core are compiled first; one clock, pclk.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_wtc_core;
  import wtc_pkg::*;
  localparam int RW = 10;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  int          n_errors;
  int          samples_checked;
  integer      seed;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [32:0] e_t;
  logic [32:0] m_t;
  logic [31:0] rdv;
  logic [15:0] rnd;
  logic [7:0]  offs[6] = '{OFF_CONTROL, OFF_COUNT, OFF_MATCH, OFF_WSTATUS, OFF_IRQ_STAT,
                           OFF_IRQ_MASK};
  logic [31:0] rvals[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_ffff, 32'h0000_0000,
                            32'h0000_0000, 32'h0000_0000};

  wtc_core #(.RW_CYC(RW), .SUB_CYC(8)) u_wtc_core (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // ----------------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic se);
    exp_q.push_back({se, e & m});
    msk_q.push_back({1'b1, m});
    apb(a, 1'b0, 32'h0000_0000);
  endtask : rd

  task automatic wait_rw();
    repeat (RW + 2) @(posedge pclk);
  endtask : wait_rw

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_irq

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // read monitor: each completed read is checked against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && msk_q.size() > 0) begin
      e_t = exp_q.pop_front();
      m_t = msk_q.pop_front();
      `CHK("read", e_t, {pslverr, prdata} & m_t)
    end
  end

  initial begin
    #(40 * 20000);
    n_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h8be6f753;
    n_errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) rd(offs[i], rvals[i], 32'hffff_ffff, 1'b0);
    rd(8'h18, 32'h0000_0000, 32'h0000_0000, 1'b1);
    $display("test reset and map done");
    wr(OFF_CONTROL, 32'h0000_0000);
    wait_rw();
    `CHK("irq masked", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    `CHK("irq raised", 1'b1, irq)
    rd(OFF_IRQ_STAT, 32'h0000_0002, 32'h0000_0002, 1'b0);
    `CHK("irq cleared", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    $display("test interrupt register done");
    wr(OFF_CONTROL, 32'h0000_0003);
    rd(OFF_WSTATUS, 32'h0000_0001, 32'h0000_0003, 1'b0);
    wr(OFF_CONTROL, 32'h0000_0005);
    wait_rw();
    rd(OFF_WSTATUS, 32'h0000_0000, 32'h0000_0003, 1'b0);
    rd(OFF_CONTROL, 32'h0000_0003, 32'h0000_007f, 1'b0);
    rnd = 16'($random(seed));
    wr(OFF_COUNT, {16'h0000, rnd});
    wr(OFF_COUNT, {16'h0000, ~rnd});
    rd(OFF_WSTATUS, 32'h0000_0002, 32'h0000_0003, 1'b0);
    wait_rw();
    rd(OFF_COUNT, {16'h0000, rnd}, 32'h0000_ffff, 1'b0);
    $display("test rewrite pending done");
    wr(OFF_COUNT, 32'h0000_0000);
    wr(OFF_MATCH, 32'h0000_0005);
    wait_rw();
    wr(OFF_CONTROL, 32'h0000_0048);
    wait_irq();
    `CHK("compare irq", 1'b1, irq)
    wr(OFF_WSTATUS, 32'h0000_0000);
    rd(OFF_WSTATUS, 32'h0000_0080, 32'h0000_0080, 1'b0);
    wr(OFF_WSTATUS, 32'h0000_0000);
    rd(OFF_WSTATUS, 32'h0000_0000, 32'h0000_0080, 1'b0);
    `CHK("flag cleared irq", 1'b0, irq)
    wr(OFF_CONTROL, 32'h0000_0000);
    wait_rw();
    rd(OFF_COUNT, 32'h0000_0000, 32'h0000_ffff, 1'b0);
    $display("test compare mode done");
    wr(OFF_COUNT, 32'h0000_fff0);
    wr(OFF_MATCH, 32'h0000_fff2);
    wait_rw();
    wr(OFF_CONTROL, 32'h0000_0068);
    repeat (RW + 4) @(posedge pclk);
    `CHK("interval no match", 1'b0, irq)
    wait_irq();
    `CHK("wrap irq", 1'b1, irq)
    rd(OFF_WSTATUS, 32'h0000_0080, 32'h0000_0080, 1'b0);
    wr(OFF_WSTATUS, 32'h0000_0000);
    wr(OFF_CONTROL, 32'h0000_0000);
    wait_rw();
    $display("test interval mode done");
    wr(OFF_CONTROL, 32'h0000_0010);
    wait_rw();
    wr(OFF_CONTROL, 32'h0000_0050);
    repeat (RW + 80) @(posedge pclk);
    rd(OFF_COUNT, 32'h0000_0000, 32'h0000_0000, 1'b0);
    `CHK("subclock count", 1'b1, (rdv >= 32'd8 && rdv <= 32'd12))
    wr(OFF_CONTROL, 32'h0000_0000);
    wait_rw();
    $display("test subclock source done");
    results();
  end
endmodule : test_wtc_core

// file: design/wtc_core.sv
/*
  watch timer core: two 16-bit counters, compare and interval modes,
  delayed register rewrites with pending flags, apb register slave.
  assumes one clock pclk; the subclock is an enable from a divider.
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// How it works
// - clearing run, once applied, stops counting and zeroes both counters
// - write-status register shows control and counter rewrites in progress
// - control write while its rewrite is pending is dropped
// - counter write while its rewrite is pending is dropped
// - two counters, system and subclock; source select picks the accessed one
// - reads return the current value even while the matching pending flag is set
// - a counter load wins over an increment in the same cycle
// - compare mode sets the flag when counter equals match value
// - interval mode sets the flag when counter wraps to zero
// - pending flag rises at rewrite start and falls at completion
// - flag clears only by writing zero after reading it as one
module wtc_core
  import wtc_pkg::*;
#(
  parameter int RW_CYC  = wtc_pkg::REWRITE_CYCLES,
  parameter int SUB_CYC = wtc_pkg::SUB_DIV
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq
);
  import wtc_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup, acc, wr, rd, mapped;
  assign setup  = psel & ~penable;
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign mapped = paddr inside {OFF_CONTROL, OFF_COUNT, OFF_MATCH,
                                OFF_WSTATUS, OFF_IRQ_STAT, OFF_IRQ_MASK};
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wtc_ctrl_t       ctrl_ff, ctrl_new_ff;
  logic [15:0]     cnt_ff [2];
  logic [15:0]     cnt_new_ff, match_ff;
  logic [7:0]      ctrl_tmr_ff, cnt_tmr_ff, presc_ff;
  logic [7:0]      sub_div_ff;
  logic            ctrl_pend_ff, cnt_pend_ff, flag_ff, arm_ff;
  logic [EV_W-1:0] ev_ff, mask_ff;
  logic [31:0]     prdata_ff;
  logic            ctrl_done, cnt_done, sub_tick, src_tick, cnt_tick;
  logic            hit, src;
  logic [7:0]      pmask;
  logic [15:0]     cur, nxt_cur;

  assign src = ctrl_ff.count_source_select;
  assign cur = cnt_ff[src];

  // ----------------------------------------------------------------
  // rewrite sequencing
  // ----------------------------------------------------------------
  assign ctrl_done = ctrl_pend_ff & (ctrl_tmr_ff == 8'h01);
  assign cnt_done  = cnt_pend_ff & (cnt_tmr_ff == 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_pend_ff <= 1'b0;
      ctrl_tmr_ff  <= 8'h00;
      ctrl_new_ff  <= CTRL_RST;
    end else if (wr && paddr == OFF_CONTROL && !ctrl_pend_ff) begin
      ctrl_pend_ff <= 1'b1;
      ctrl_tmr_ff  <= 8'(RW_CYC);
      ctrl_new_ff  <= pwdata[CTRL_W-1:0];
    end else if (ctrl_pend_ff) begin
      ctrl_tmr_ff  <= ctrl_tmr_ff - 8'h01;
      if (ctrl_done) ctrl_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_pend_ff <= 1'b0;
      cnt_tmr_ff  <= 8'h00;
      cnt_new_ff  <= COUNT_RST;
    end else if (wr && paddr == OFF_COUNT && !cnt_pend_ff) begin
      cnt_pend_ff <= 1'b1;
      cnt_tmr_ff  <= 8'(RW_CYC);
      cnt_new_ff  <= pwdata[15:0];
    end else if (cnt_pend_ff) begin
      cnt_tmr_ff  <= cnt_tmr_ff - 8'h01;
      if (cnt_done) cnt_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_ff <= CTRL_RST;
    else if (ctrl_done) ctrl_ff <= ctrl_new_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) match_ff <= MATCH_RST;
    else if (wr && paddr == OFF_MATCH) match_ff <= pwdata[15:0];
  end

  // ----------------------------------------------------------------
  // clock sources and prescaler
  // ----------------------------------------------------------------
  assign sub_tick = (sub_div_ff == 8'(SUB_CYC - 1));
  assign src_tick = src ? sub_tick : 1'b1;
  assign pmask    = ~(8'hff << ctrl_ff.prescale_select);
  assign cnt_tick = ctrl_ff.count_run & src_tick & ((presc_ff & pmask) == pmask);
  assign nxt_cur  = cur + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sub_div_ff <= 8'h00;
    else if (sub_tick) sub_div_ff <= 8'h00;
    else sub_div_ff <= sub_div_ff + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) presc_ff <= 8'h00;
    else if (!ctrl_ff.count_run) presc_ff <= 8'h00;
    else if (src_tick) presc_ff <= presc_ff + 8'h01;
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_cnt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_ff[i] <= COUNT_RST;
      else if (ctrl_done && !ctrl_new_ff.count_run) cnt_ff[i] <= COUNT_RST;
      else if (cnt_done && src == 1'(i)) cnt_ff[i] <= cnt_new_ff;
      else if (cnt_tick && src == 1'(i)) cnt_ff[i] <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // match or wrap flag
  // ----------------------------------------------------------------
  assign hit = cnt_tick && !cnt_done &&
               (ctrl_ff.timer_mode_select ? (cur == COUNT_TOP)
                                          : (nxt_cur == match_ff));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) arm_ff <= 1'b0;
    else if (rd && paddr == OFF_WSTATUS) arm_ff <= prdata_ff[WS_FLAG_BIT];
    else if (wr && paddr == OFF_WSTATUS) arm_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_ff <= 1'b0;
    else if (hit) flag_ff <= 1'b1;
    else if (wr && paddr == OFF_WSTATUS && arm_ff && !pwdata[WS_FLAG_BIT])
      flag_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // sticky events, read clears, set wins
  // ----------------------------------------------------------------
  logic [EV_W-1:0] ev_set;
  always_comb begin
    ev_set              = '0;
    ev_set[EV_FLAG_BIT] = hit;
    ev_set[EV_CTRL_BIT] = ctrl_done;
    ev_set[EV_CNT_BIT]  = cnt_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ev_ff <= '0;
    else if (rd && paddr == OFF_IRQ_STAT) ev_ff <= ev_set | (ev_ff & ~prdata_ff[EV_W-1:0]);
    else ev_ff <= ev_ff | ev_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_ff <= '0;
    else if (wr && paddr == OFF_IRQ_MASK) mask_ff <= pwdata[EV_W-1:0];
  end

  assign irq = (flag_ff & ctrl_ff.irq_enable) | (|(ev_ff & mask_ff));

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_ff <= 32'h0000_0000;
    else if (setup && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      case (paddr)
        OFF_CONTROL:  prdata_ff[CTRL_W-1:0] <= ctrl_ff;
        OFF_COUNT:    prdata_ff[15:0] <= cur;
        OFF_MATCH:    prdata_ff[15:0] <= match_ff;
        OFF_WSTATUS: begin
          prdata_ff[WS_CTRL_BIT] <= ctrl_pend_ff;
          prdata_ff[WS_CNT_BIT]  <= cnt_pend_ff;
          prdata_ff[WS_FLAG_BIT] <= flag_ff;
        end
        OFF_IRQ_STAT: prdata_ff[EV_W-1:0] <= ev_ff;
        OFF_IRQ_MASK: prdata_ff[EV_W-1:0] <= mask_ff;
        default:      prdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  stop_clears_a: assert property (
    ctrl_done && !ctrl_new_ff.count_run |=> cnt_ff[0] == 16'h0000 && cnt_ff[1] == 16'h0000)
    else $error("counters not zeroed on stop");
  ctrl_pend_a: assert property (
    wr && paddr == OFF_CONTROL && !ctrl_pend_ff |=> ctrl_pend_ff)
    else $error("control pending flag not raised");
  ctrl_drop_a: assert property (
    wr && paddr == OFF_CONTROL && ctrl_pend_ff |=> $stable(ctrl_new_ff))
    else $error("control write not dropped");
  cnt_drop_a: assert property (
    wr && paddr == OFF_COUNT && cnt_pend_ff |=> $stable(cnt_new_ff))
    else $error("count write not dropped");
  load_wins_a: assert property (
    cnt_done && !(ctrl_done && !ctrl_new_ff.count_run) |=>
      ($past(src) ? cnt_ff[1] : cnt_ff[0]) == $past(cnt_new_ff))
    else $error("count load lost to increment");
  pend_ends_a: assert property (
    $rose(cnt_pend_ff) |-> ##[1:RW_CYC] !cnt_pend_ff)
    else $error("count rewrite never completes");
  ctrl_pend_end_a: assert property (
    $rose(ctrl_pend_ff) |-> ##[1:RW_CYC] !ctrl_pend_ff)
    else $error("control rewrite never completes");
  cnt_pend_a: assert property (
    wr && paddr == OFF_COUNT && !cnt_pend_ff |=> cnt_pend_ff)
    else $error("count pending flag not raised");
  ctrl_hold_a: assert property (
    !ctrl_done |=> $stable(ctrl_ff))
    else $error("control changed outside rewrite completion");
  ctrl_apply_a: assert property (
    ctrl_done |=> ctrl_ff == $past(ctrl_new_ff) && !ctrl_pend_ff)
    else $error("control rewrite not applied");
  stop_hold_a: assert property (
    !ctrl_ff.count_run && !cnt_done && !ctrl_done |=> $stable(cnt_ff[0]) && $stable(cnt_ff[1]))
    else $error("stopped counter moved");
  sub_rate_a: assert property (
    cnt_tick && src |-> sub_tick)
    else $error("subclock counter stepped off its tick");
  match_set_a: assert property (
    cnt_tick && !cnt_done && !ctrl_ff.timer_mode_select && nxt_cur == match_ff |=> flag_ff)
    else $error("match did not set flag");
  wrap_set_a: assert property (
    cnt_tick && !cnt_done && ctrl_ff.timer_mode_select && cur == 16'hffff |=> flag_ff)
    else $error("wrap did not set flag");
  flag_hold_a: assert property (
    flag_ff && !arm_ff |=> flag_ff)
    else $error("flag cleared without prior read");
  irq_level_a: assert property (
    flag_ff && ctrl_ff.irq_enable |-> irq)
    else $error("interrupt missing");
  irq_quiet_a: assert property (
    !(flag_ff && ctrl_ff.irq_enable) && !(|(ev_ff & mask_ff)) |-> !irq)
    else $error("interrupt without cause");
  flag_clear_a: assert property (
    wr && paddr == OFF_WSTATUS && arm_ff && !pwdata[WS_FLAG_BIT] && !hit |=> !flag_ff)
    else $error("armed flag clear ignored");
  arm_read_a: assert property (
    rd && paddr == OFF_WSTATUS |=> arm_ff == $past(prdata_ff[WS_FLAG_BIT]))
    else $error("arm does not follow the value read");
  ev_keep_a: assert property (
    ev_set[EV_CTRL_BIT] |=> ev_ff[EV_CTRL_BIT])
    else $error("rewrite done event lost");

  // ----------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------
  run_cov: cover property (ctrl_done && ctrl_new_ff.count_run);
  wrap_cov: cover property (hit && ctrl_ff.timer_mode_select);
  drop_cov: cover property (wr && paddr == OFF_CONTROL && ctrl_pend_ff);
  match_cov: cover property (hit && !ctrl_ff.timer_mode_select);
  cnt_drop_cov: cover property (wr && paddr == OFF_COUNT && cnt_pend_ff);
endmodule : wtc_core

// file: design/wtc_pkg.sv
/*
  watch timer package: register offsets, field positions, reset values,
  control carrier and timing constants.
  assumes a 32-bit apb with byte addresses; one word per register.
*/
package wtc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL  = 8'h00;
  localparam logic [7:0] OFF_COUNT    = 8'h04;
  localparam logic [7:0] OFF_MATCH    = 8'h08;
  localparam logic [7:0] OFF_WSTATUS  = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_W       = 7;
  localparam int WS_CTRL_BIT  = 0;
  localparam int WS_CNT_BIT   = 1;
  localparam int WS_FLAG_BIT  = 7;
  localparam int EV_W         = 3;
  localparam int EV_FLAG_BIT  = 0;
  localparam int EV_CTRL_BIT  = 1;
  localparam int EV_CNT_BIT   = 2;
  // ----------------------------------------------------------------
  // reset values and counter top
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] MATCH_RST = 16'hffff;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int REWRITE_CYCLES = 3;
  localparam int SUB_DIV        = 8;
  // ----------------------------------------------------------------
  // control carrier: run, mode (1 = interval), source (1 = sub),
  // irq enable, prescale select
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       count_run;
    logic       timer_mode_select;
    logic       count_source_select;
    logic       irq_enable;
    logic [2:0] prescale_select;
  } wtc_ctrl_t;
  localparam wtc_ctrl_t CTRL_RST = '0;
endpackage : wtc_pkg
